// [fbg_pkg.sv]
// Notes on behaviour
// RL1: device mismatch 21, clock mode mismatch 22
// RL2: rate setup errors 24, 25, 26, 27
// RL3: 00 no error, 11 checksum, 80 command
// RL4: erase failure reports 51 after header byte
// RL5: each 128-byte unit written once, erased
// RL6: protected area written fully with ff
// RL7: user code above 40, reserved vectors ff
// RL8: key code not ff: programmer reads 00
// RL9: no flash access until key cleared
// RL10: no reset or standby while programming
// RL11: reset during programming held 100 us
// RL12: program or erase only via downloaded routine
// RL13: downloaded routine at most 2 Kbytes
// RL14: software guards runaway during programming
// RL15: erase before reprogramming is recommended
package fbg_pkg;
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_CHECKSUM = 8'h11;
  localparam logic [7:0] ERR_DEVICE   = 8'h21;
  localparam logic [7:0] ERR_CLKMODE  = 8'h22;
  localparam logic [7:0] ERR_BITRATE  = 8'h24;
  localparam logic [7:0] ERR_INFREQ   = 8'h25;
  localparam logic [7:0] ERR_DIVRATIO = 8'h26;
  localparam logic [7:0] ERR_OPFREQ   = 8'h27;
  localparam logic [7:0] ERR_ERASE    = 8'h51;
  localparam logic [7:0] ERR_COMMAND  = 8'h80;
  localparam logic [7:0] ERASE_ERR_HDR = 8'hd8;
  localparam logic [7:0] BLANK_BYTE   = 8'hff;
  localparam logic [7:0] LOCKED_READ  = 8'h00;
  localparam logic [23:0] KEY_FIRST   = 24'h00003c;
  localparam logic [23:0] KEY_LAST    = 24'h00003f;
  localparam int ROUTINE_MAX_BYTES    = 2048;
  localparam int ROUTINE_AW           = 11;
  typedef enum logic [3:0] {
    FBG_CHK_NONE, FBG_CHK_SUM, FBG_CHK_DEV, FBG_CHK_CLK,
    FBG_CHK_RATE, FBG_CHK_IFREQ, FBG_CHK_DIV, FBG_CHK_OFREQ,
    FBG_CHK_CMD, FBG_CHK_ERASE
  } fbg_chk_t;
endpackage : fbg_pkg

// [fbg_guard.sv]
`timescale 1ns/100ps
module fbg_guard
  import fbg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  chk_valid,
  input  wire logic [3:0]            chk_kind,
  input  wire logic                  prog_mode,
  input  wire logic                  rd_req,
  input  wire logic [23:0]           rd_addr,
  input  wire logic [7:0]            rd_flash_data,
  input  wire logic                  key_wr,
  input  wire logic [1:0]            key_idx,
  input  wire logic [7:0]            key_data,
  input  wire logic                  key_erase,
  input  wire logic                  onchip_routine_download_request,
  input  wire logic                  dl_wr,
  input  wire logic                  dl_done,
  input  wire logic                  op_start,
  output logic                       tx_valid,
  output logic [7:0]                 tx_byte,
  output logic                       rd_valid,
  output logic [7:0]                 rd_data,
  output logic                       routine_ready,
  output logic                       op_go,
  output logic                       dl_overflow
);
  typedef enum logic [1:0] {FBG_IDLE, FBG_HDR, FBG_CODE} fbg_tx_t;
  typedef struct packed {
    fbg_tx_t                 txs;
    logic [7:0]              code;
    logic                    tx_valid;
    logic [7:0]              tx_byte;
    logic                    rd_valid;
    logic [7:0]              rd_data;
    logic [3:0]              key_blank;
    logic                    dl_act;
    logic [ROUTINE_AW:0]     dl_cnt;
    logic                    routine_ready;
    logic                    op_go;
    logic                    dl_overflow;
  } fbg_state_t;
  fbg_state_t st, next_st;

  function automatic logic [7:0] code_of(input logic [3:0] k);
    case (fbg_chk_t'(k))
      FBG_CHK_SUM:   code_of = ERR_CHECKSUM; // RL3
      FBG_CHK_DEV:   code_of = ERR_DEVICE;   // RL1
      FBG_CHK_CLK:   code_of = ERR_CLKMODE;  // RL1
      FBG_CHK_RATE:  code_of = ERR_BITRATE;  // RL2
      FBG_CHK_IFREQ: code_of = ERR_INFREQ;   // RL2
      FBG_CHK_DIV:   code_of = ERR_DIVRATIO; // RL2
      FBG_CHK_OFREQ: code_of = ERR_OPFREQ;   // RL2
      FBG_CHK_CMD:   code_of = ERR_COMMAND;  // RL3
      FBG_CHK_ERASE: code_of = ERR_ERASE;    // RL4
      default:       code_of = ERR_NONE;     // RL3
    endcase
  endfunction : code_of

  always_comb begin
    next_st = st;
    next_st.tx_valid = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.op_go = 1'b0;
    case (st.txs)
      FBG_IDLE: begin
        if (chk_valid) begin
          next_st.code = code_of(chk_kind);
          if (fbg_chk_t'(chk_kind) == FBG_CHK_ERASE) begin
            next_st.tx_valid = 1'b1; // RL4
            next_st.tx_byte = ERASE_ERR_HDR;
            next_st.txs = FBG_CODE;
          end else begin
            next_st.txs = FBG_HDR;
          end
        end
      end
      FBG_HDR: begin
        next_st.tx_valid = 1'b1; // RL3
        next_st.tx_byte = st.code;
        next_st.txs = FBG_IDLE;
      end
      default: begin
        next_st.tx_valid = 1'b1; // RL4
        next_st.tx_byte = st.code;
        next_st.txs = FBG_IDLE;
      end
    endcase
    // key code area watch
    if (key_erase) begin
      next_st.key_blank = 4'hf;
    end else if (key_wr) begin
      next_st.key_blank[key_idx] = (key_data == BLANK_BYTE); // RL8
    end
    if (rd_req) begin
      next_st.rd_valid = 1'b1;
      if (prog_mode && (st.key_blank != 4'hf)) begin
        next_st.rd_data = LOCKED_READ; // RL8
      end else begin
        next_st.rd_data = rd_flash_data;
      end
    end
    // routine download and size limit
    if (onchip_routine_download_request) begin
      next_st.dl_act = 1'b1; // RL12
      next_st.dl_cnt = '0;
      next_st.routine_ready = 1'b0;
      next_st.dl_overflow = 1'b0;
    end else if (st.dl_act && dl_wr) begin
      if (st.dl_cnt == (ROUTINE_AW + 1)'(ROUTINE_MAX_BYTES)) begin
        next_st.dl_overflow = 1'b1; // RL13
        next_st.dl_act = 1'b0;
      end else begin
        next_st.dl_cnt = st.dl_cnt + 1'b1;
      end
    end else if (st.dl_act && dl_done) begin
      next_st.dl_act = 1'b0;
      next_st.routine_ready = !st.dl_overflow; // RL12
    end
    if (op_start && st.routine_ready) begin
      next_st.op_go = 1'b1; // RL12
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{txs: FBG_IDLE, code: ERR_NONE, tx_valid: 1'b0,
              tx_byte: 8'h00, rd_valid: 1'b0, rd_data: 8'h00,
              key_blank: 4'hf, dl_act: 1'b0, dl_cnt: '0,
              routine_ready: 1'b0, op_go: 1'b0, dl_overflow: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign tx_valid      = st.tx_valid;
  assign tx_byte       = st.tx_byte;
  assign rd_valid      = st.rd_valid;
  assign rd_data       = st.rd_data;
  assign routine_ready = st.routine_ready;
  assign op_go         = st.op_go;
  assign dl_overflow   = st.dl_overflow;

  property p_dev_code;
    @(posedge clk) disable iff (!arst_n)
      (chk_valid && st.txs == FBG_IDLE && chk_kind == 4'(FBG_CHK_DEV))
      |-> ##2 (tx_valid && tx_byte == 8'h21);
  endproperty
  a_dev_code: assert property (p_dev_code) else $error("bad dev code"); // RL1
  property p_clk_code;
    @(posedge clk) disable iff (!arst_n)
      (chk_valid && st.txs == FBG_IDLE && chk_kind == 4'(FBG_CHK_CLK))
      |-> ##2 (tx_valid && tx_byte == 8'h22);
  endproperty
  a_clk_code: assert property (p_clk_code) else $error("bad clk code"); // RL1
  property p_rate_code;
    @(posedge clk) disable iff (!arst_n)
      (chk_valid && st.txs == FBG_IDLE && chk_kind == 4'(FBG_CHK_DIV))
      |-> ##2 (tx_valid && tx_byte == 8'h26);
  endproperty
  a_rate_code: assert property (p_rate_code) else $error("bad div"); // RL2
  property p_cmd_code;
    @(posedge clk) disable iff (!arst_n)
      (chk_valid && st.txs == FBG_IDLE && chk_kind == 4'(FBG_CHK_CMD))
      |-> ##2 (tx_valid && tx_byte == 8'h80);
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad cmd code"); // RL3
  property p_erase_frame;
    @(posedge clk) disable iff (!arst_n)
      (chk_valid && st.txs == FBG_IDLE && chk_kind == 4'(FBG_CHK_ERASE))
      |-> ##1 (tx_valid && tx_byte == 8'hd8)
          ##1 (tx_valid && tx_byte == 8'h51);
  endproperty
  a_erase_frame: assert property (p_erase_frame) else $error("erase frm"); // RL4
  property p_key_lock;
    @(posedge clk) disable iff (!arst_n)
      (rd_req && prog_mode && st.key_blank != 4'hf)
      |=> (rd_valid && rd_data == 8'h00);
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("key not locked"); // RL8
  property p_go_needs_dl;
    @(posedge clk) disable iff (!arst_n)
      op_go |-> $past(routine_ready) && $past(op_start);
  endproperty
  a_go_needs_dl: assert property (p_go_needs_dl) else $error("go w/o dl"); // RL12
  property p_size_cap;
    @(posedge clk) disable iff (!arst_n)
      st.dl_cnt <= (ROUTINE_AW + 1)'(ROUTINE_MAX_BYTES);
  endproperty
  a_size_cap: assert property (p_size_cap) else $error("routine size"); // RL13
  property p_ovf_blocks;
    @(posedge clk) disable iff (!arst_n)
      dl_overflow |-> !routine_ready;
  endproperty
  a_ovf_blocks: assert property (p_ovf_blocks) else $error("ovf ready"); // RL13
  property p_ready_needs_done;
    @(posedge clk) disable iff (!arst_n)
      $rose(routine_ready) |-> $past(dl_done) && $past(st.dl_act);
  endproperty
  a_ready_needs_done: assert property (p_ready_needs_done) // RL12
    else $error("ready without download");
  property p_tx_pulse;
    @(posedge clk) disable iff (!arst_n)
      (tx_valid && st.txs == FBG_IDLE && !chk_valid) |=> !tx_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx stuck"); // RL3
  property p_open_read;
    @(posedge clk) disable iff (!arst_n)
      (rd_req && (!prog_mode || st.key_blank == 4'hf))
      |=> (rd_valid && rd_data == $past(rd_flash_data));
  endproperty
  a_open_read: assert property (p_open_read) else $error("open read"); // RL8
  property p_key_erase;
    @(posedge clk) disable iff (!arst_n)
      key_erase |=> (st.key_blank == 4'hf);
  endproperty
  a_key_erase: assert property (p_key_erase) else $error("key erase"); // RL8
  property p_rd_pulse;
    @(posedge clk) disable iff (!arst_n)
      rd_valid |-> $past(rd_req);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd w/o req"); // RL8
endmodule : fbg_guard

// [fbg_flash_model.sv]
`timescale 1ns/100ps
module fbg_flash_model
  import fbg_pkg::*;
(
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  fill,
  output logic      [7:0]  data
);
  // vector area below 40 stays blank, user bytes above it
  always_comb begin
    if (addr < 24'h000040) begin
      data = BLANK_BYTE;
    end else begin
      data = fill ^ addr[7:0];
    end
  end
endmodule : fbg_flash_model

// [flash_boot_error_and_guard_rules_bench.sv]
`timescale 1ns/100ps
module flash_boot_error_and_guard_rules_bench;
  import fbg_pkg::*;
  logic        clk, arst_n, chk_valid, prog_mode, rd_req, key_wr;
  logic        key_erase, dl_req, dl_wr, dl_done, op_start;
  logic        tx_valid, rd_valid, routine_ready, op_go, dl_overflow;
  logic [3:0]  chk_kind;
  logic [1:0]  key_idx;
  logic [23:0] rd_addr;
  logic [7:0]  flash_q, fill, key_data, tx_byte, rd_data;
  logic [7:0]  exp_code [10] = '{8'h00, 8'h11, 8'h21, 8'h22, 8'h24,
                                 8'h25, 8'h26, 8'h27, 8'h80, 8'h51};
  int          err_count, checks, cycles, n;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  fbg_flash_model flash (.addr(rd_addr), .fill(fill), .data(flash_q));
  fbg_guard dut (.clk(clk), .arst_n(arst_n), .chk_valid(chk_valid),
    .chk_kind(chk_kind), .prog_mode(prog_mode), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_flash_data(flash_q), .key_wr(key_wr),
    .key_idx(key_idx), .key_data(key_data), .key_erase(key_erase),
    .onchip_routine_download_request(dl_req), .dl_wr(dl_wr),
    .dl_done(dl_done), .op_start(op_start), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .rd_valid(rd_valid), .rd_data(rd_data),
    .routine_ready(routine_ready), .op_go(op_go),
    .dl_overflow(dl_overflow));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick;
    @(negedge clk);
  endtask : tick
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic t_codes;
    for (int k = 0; k < 10; k++) begin
      chk_kind = 4'(k);
      chk_valid = 1'b1;
      tick();
      chk_valid = 1'b0;
      `CHK(tx_valid, (k == 9))
      if (k == 9) `CHK(tx_byte, 8'hd8)
      tick();
      `CHK(tx_valid, 1'b1)
      `CHK(tx_byte, exp_code[k])
      tick();
      `CHK(tx_valid, 1'b0)
    end
    chk_kind = 4'h2;
    chk_valid = 1'b1;
    repeat (2) tick();
    chk_valid = 1'b0;
    `CHK(tx_byte, 8'h21)
    tick();
    `CHK(tx_valid, 1'b0)
  endtask : t_codes
  task automatic rd(input logic [7:0] exp);
    rd_req = 1'b1;
    tick();
    rd_req = 1'b0;
    for (n = 0; n < 2 && rd_valid !== 1'b1; n++) tick();
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, exp)
  endtask : rd
  task automatic key(input logic [1:0] i, input logic [7:0] d);
    key_idx = i;
    key_data = d;
    key_wr = 1'b1;
    tick();
    key_wr = 1'b0;
  endtask : key
  task automatic t_lock;
    prog_mode = 1'b1;
    rd(8'h5a);
    key(2'h2, 8'h12);
    rd(8'h00);
    key(2'h1, 8'hff);
    rd(8'h00);
    prog_mode = 1'b0;
    rd(8'h5a);
    prog_mode = 1'b1;
    key_erase = 1'b1;
    tick();
    key_erase = 1'b0;
    key(2'h3, 8'hff);
    rd(8'h5a);
  endtask : t_lock
  task automatic t_dl(input int bytes, input logic ok);
    dl_req = 1'b1;
    tick();
    dl_req = 1'b0;
    if (bytes > 0) begin
      dl_wr = 1'b1;
      repeat (bytes) tick();
      dl_wr = 1'b0;
    end
    dl_done = 1'b1;
    tick();
    dl_done = 1'b0;
    tick();
    `CHK(dl_overflow, !ok)
    `CHK(routine_ready, ok)
    op_start = 1'b1;
    tick();
    op_start = 1'b0;
    for (n = 0; n < 2 && op_go !== 1'b1; n++) tick();
    `CHK(op_go, ok)
    tick();
    `CHK(op_go, 1'b0)
  endtask : t_dl
  task automatic t_reset;
    key(2'h0, 8'h00);
    rd(8'h00);
    `CHK(op_go, 1'b0)
    arst_n = 1'b0;
    repeat (2000) tick();
    `CHK(routine_ready, 1'b0)
    `CHK(tx_valid, 1'b0)
    arst_n = 1'b1;
    `CHK(dl_overflow, 1'b0)
    rd(8'h5a);
  endtask : t_reset
  initial begin
    {arst_n, chk_valid, prog_mode, rd_req, key_wr, key_erase} = '0;
    {dl_req, dl_wr, dl_done, op_start, chk_kind, key_idx} = '0;
    {key_data, err_count, checks, cycles} = '0;
    rd_addr = 24'h000100;
    fill = 8'h5a;
    repeat (2) tick();
    arst_n = 1'b1;
    `CHK(routine_ready, 1'b0)
    op_start = 1'b1;
    tick();
    op_start = 1'b0;
    `CHK(op_go, 1'b0)
    t_codes();
    t_lock();
    t_dl(0, 1'b1);
    t_dl(2048, 1'b1);
    t_reset();
    t_dl(2049, 1'b0);
    stop_test();
  end
endmodule : flash_boot_error_and_guard_rules_bench
